// ---- core/ilod_consts.svh ----
// Constants for the indexed literal offset operand decoder
`ifndef ILOD_CONSTS_SVH
`define ILOD_CONSTS_SVH
`define ILOD_ADDR_W 12
`define ILOD_FIELD_W 8
`define ILOD_BANK_W 4
`define ILOD_OFFSET_MAX 8'h5f
`define ILOD_ACCESS_SPLIT 8'h60
`define ILOD_ACCESS_HIGH_BANK 4'hf
`define ILOD_OPC_W 16
`define ILOD_EXT_COUNT 4'h8
`define ILOD_EXT_PREFIX 8'he8
`define ILOD_EXT_PAGE_HI 15
`define ILOD_EXT_PAGE_LO 8
`define ILOD_EXT_SLOT_HI 7
`define ILOD_EXT_SLOT_LO 4
`define ILOD_ADDR_RST 12'h000
`define ILOD_MODE_RST 2'h0
`endif

// ---- core/ilod_pkg.sv ----
// Types for the indexed literal offset operand decoder
package ilod_pkg;
  typedef enum logic [1:0] {
    ILOD_MODE_ACCESS,
    ILOD_MODE_BANKED,
    ILOD_MODE_INDEXED
  } ilod_mode_e;
endpackage

// ---- core/ilod_ext_decode.sv ----
// Recogniser for the extension opcodes, gated by the shared enable
`include "ilod_consts.svh"
module ilod_ext_decode (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Opcode in
  input wire logic [`ILOD_OPC_W-1:0] opcode,
  input wire logic ext_en,
  // Result
  output logic ext_hit_q
);
  logic page_w;
  logic slot_w;

  // Page and slot fields of the opcode
  assign page_w = opcode[`ILOD_EXT_PAGE_HI:`ILOD_EXT_PAGE_LO] == `ILOD_EXT_PREFIX;
  assign slot_w = opcode[`ILOD_EXT_SLOT_HI:`ILOD_EXT_SLOT_LO] < `ILOD_EXT_COUNT;

  // Extension opcodes sit in one page; only decoded when enabled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_hit_q <= 1'b0;
    end else begin
      ext_hit_q <= ext_en && page_w && slot_w; // RQ7
    end
  end
endmodule

// ---- core/ilod_decode.sv ----
// Operand address resolution with indexed literal offset mode
// Notes on behaviour
// RQ1: Extension off, access bit 0: field is a literal access-bank location.
// RQ2: Extension off, access bit 1: bank select register chooses bank, field locates.
// RQ3: Extension on, access bit 0, field up to 5Fh: pointer plus field.
// RQ4: Fields above 5Fh keep literal addressing even when extension on.
// RQ5: Destination select behaves the same whether extension on or off.
// RQ6: Pointer at 00h makes offset mode match the plain access bank.
// RQ7: One enable adds the eight new opcodes and switches on offset mode.
// RQ8: Offset resolution applies to every byte and bit operation alike.
// RQ9: Extension on with access bit 1 uses bank select, no offset.
`include "ilod_consts.svh"
module ilod_decode (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Instruction fields
  input wire logic [`ILOD_OPC_W-1:0] opcode,
  input wire logic instr_valid,
  input wire logic has_access_bit,
  input wire logic [`ILOD_FIELD_W-1:0] file_field,
  input wire logic access_sel,
  input wire logic dest_sel,
  // Core state
  input wire logic ext_en,
  input wire logic [`ILOD_ADDR_W-1:0] indexed_base_pointer,
  input wire logic [`ILOD_BANK_W-1:0] bank_select_register,
  // Results
  output logic [`ILOD_ADDR_W-1:0] eff_addr_q,
  output logic addr_valid_q,
  output logic dest_to_file_q,
  output logic [1:0] mode_q,
  output logic ext_opcode_q
);
  ilod_pkg::ilod_mode_e mode_d;
  logic [`ILOD_ADDR_W-1:0] addr_d;
  logic [`ILOD_ADDR_W-1:0] sum_w;
  logic take_w;

  // Offset add wraps in the data space; pointer is a full address
  // Carry out of the top bit is dropped: a stack near the top wraps round
  assign sum_w = indexed_base_pointer + {4'h0, file_field}; // RQ3

  // An operand is taken only from byte or bit operations carrying the access bit
  assign take_w = instr_valid && has_access_bit; // RQ8

  // Mode choice; one enable shared with the opcode recogniser
  // The access bit is tested first, so a set bit never takes an offset
  always_comb begin
    mode_d = ilod_pkg::ILOD_MODE_ACCESS; // RQ1
    if (access_sel) begin
      mode_d = ilod_pkg::ILOD_MODE_BANKED; // RQ2 RQ9
    end else if (ext_en && file_field <= `ILOD_OFFSET_MAX) begin
      mode_d = ilod_pkg::ILOD_MODE_INDEXED; // RQ3 RQ4 RQ7
    end
  end

  // Address formation; same path for every byte or bit operation
  always_comb begin
    case (mode_d)
      ilod_pkg::ILOD_MODE_BANKED: addr_d = {bank_select_register, file_field}; // RQ2 RQ9
      ilod_pkg::ILOD_MODE_INDEXED: addr_d = sum_w; // RQ3 RQ8
      ilod_pkg::ILOD_MODE_ACCESS: begin
        // Low part of access bank is bank 0, upper part is the SFR bank
        if (file_field < `ILOD_ACCESS_SPLIT) begin
          addr_d = {4'h0, file_field}; // RQ1 RQ6
        end else begin
          addr_d = {`ILOD_ACCESS_HIGH_BANK, file_field}; // RQ1 RQ4
        end
      end
      default: addr_d = {4'h0, file_field};
    endcase
  end

  // Registered address; held when no operand instruction
  // Holding the last address lets a later stage reuse it without a new decode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      eff_addr_q <= `ILOD_ADDR_RST;
      mode_q <= `ILOD_MODE_RST;
    end else if (take_w) begin
      eff_addr_q <= addr_d; // RQ8
      mode_q <= mode_d;
    end
  end

  // Valid strobe for the resolved address
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_valid_q <= 1'b0;
    end else begin
      addr_valid_q <= take_w; // RQ8
    end
  end

  // Destination passes through untouched by the extension
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dest_to_file_q <= 1'b0;
    end else if (instr_valid) begin
      dest_to_file_q <= dest_sel; // RQ5
    end
  end

  // New opcode recogniser, gated by the same enable
  ilod_ext_decode u_ext (
    .clk(clk),
    .rst_n(rst_n),
    .opcode(opcode),
    .ext_en(ext_en),
    .ext_hit_q(ext_opcode_q)
  );

  // Checks, all on the core clock and quiet while reset is held
  // Sequences name the operand classes; the low and banked properties add the enable, the high, any and none ones do not
  // Operand taken with the access bit clear and a field inside the offset window
  sequence s_take_low;
    instr_valid && has_access_bit && !access_sel && file_field <= `ILOD_OFFSET_MAX;
  endsequence

  // Operand taken with the access bit clear and a field above the window
  sequence s_take_high;
    instr_valid && has_access_bit && !access_sel && file_field > `ILOD_OFFSET_MAX;
  endsequence

  // Operand taken through the bank select register
  sequence s_take_banked;
    instr_valid && has_access_bit && access_sel;
  endsequence

  // Any operand taken at all
  sequence s_take_any;
    instr_valid && has_access_bit;
  endsequence

  // No operand this cycle, so the address side must stand still
  sequence s_take_none;
    !(instr_valid && has_access_bit);
  endsequence

  // Extension page with a slot in the lower half
  sequence s_ext_code;
    opcode[`ILOD_EXT_PAGE_HI:`ILOD_EXT_PAGE_LO] == `ILOD_EXT_PREFIX
    && opcode[`ILOD_EXT_SLOT_HI:`ILOD_EXT_SLOT_LO] < `ILOD_EXT_COUNT;
  endsequence

  // Plain access bank with the extension off
  access_literal_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_take_low and !ext_en |=> eff_addr_q == {4'h0, $past(file_field)}) // RQ1
    else $error("access literal address wrong");
  access_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_take_low and !ext_en |=> mode_q == 2'h0) // RQ1
    else $error("access literal mode wrong");

  // Banked operands, with and without the extension
  banked_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_take_banked and !ext_en
    |=> eff_addr_q == {$past(bank_select_register), $past(file_field)}) // RQ2
    else $error("banked address wrong");
  banked_ext_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_take_banked and ext_en
    |=> mode_q == 2'h1) // RQ9
    else $error("offset used with access bit set");
  banked_ext_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_take_banked and ext_en
    |=> eff_addr_q == {$past(bank_select_register), $past(file_field)}) // RQ9
    else $error("banked address wrong with extension on");

  // Offset window: pointer plus field
  // Sum is checked modulo the address width, as the hardware wraps
  indexed_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_take_low and ext_en
    |=> eff_addr_q == $past(indexed_base_pointer) + {4'h0, $past(file_field)}) // RQ3
    else $error("indexed address wrong");
  indexed_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_take_low and ext_en |=> mode_q == 2'h2) // RQ3
    else $error("indexed mode wrong");
  zero_pointer_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_take_low and (ext_en && indexed_base_pointer == 12'h000)
    |=> eff_addr_q == {4'h0, $past(file_field)}) // RQ6
    else $error("zero pointer mismatch");

  // Fields above the window keep the literal mapping
  high_literal_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_take_high |=> eff_addr_q == {`ILOD_ACCESS_HIGH_BANK, $past(file_field)}) // RQ4
    else $error("high field not literal");
  high_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_take_high |=> mode_q == 2'h0) // RQ4
    else $error("high field took offset mode");

  // Destination select is untouched by the extension
  dest_pass_a: assert property (@(posedge clk) disable iff (!rst_n)
    instr_valid |=> dest_to_file_q == $past(dest_sel)) // RQ5
    else $error("destination changed");
  dest_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    !instr_valid |=> $stable(dest_to_file_q)) // RQ5
    else $error("destination moved without instruction");

  // Extension opcodes appear only under the shared enable
  ext_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    !ext_en |=> !ext_opcode_q) // RQ7
    else $error("ext opcode while disabled");
  ext_hit_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_ext_code and ext_en |=> ext_opcode_q) // RQ7
    else $error("ext opcode missed");
  ext_miss_a: assert property (@(posedge clk) disable iff (!rst_n)
    !(opcode[`ILOD_EXT_PAGE_HI:`ILOD_EXT_PAGE_LO] == `ILOD_EXT_PREFIX
    && opcode[`ILOD_EXT_SLOT_HI:`ILOD_EXT_SLOT_LO] < `ILOD_EXT_COUNT) |=> !ext_opcode_q) // RQ7
    else $error("ext opcode outside its slots");

  // Address valid strobe follows every taken operand for one cycle
  // A missing strobe would let the data path use a stale address
  valid_strobe_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_take_any |=> addr_valid_q) // RQ8
    else $error("valid strobe missing");
  valid_drop_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_take_none |=> !addr_valid_q) // RQ8
    else $error("valid strobe without operand");
  addr_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_take_none |=> $stable(eff_addr_q)) // RQ8
    else $error("address moved without operand");
  mode_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_take_none |=> $stable(mode_q)) // RQ8
    else $error("mode moved without operand");

endmodule

// ---- testbench/ilod_decode_tb_top.sv ----
// Self-checking bench for the operand address decoder
`include "ilod_consts.svh"
module ilod_decode_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, instr_valid, has_access_bit, access_sel, dest_sel, ext_en;
  logic [`ILOD_OPC_W-1:0] opcode;
  logic [`ILOD_FIELD_W-1:0] file_field;
  logic [`ILOD_ADDR_W-1:0] indexed_base_pointer, eff_addr_q;
  logic [`ILOD_BANK_W-1:0] bank_select_register;
  logic addr_valid_q, dest_to_file_q, ext_opcode_q;
  logic [1:0] mode_q;
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;
  ilod_decode dut_u (.clk(clk), .rst_n(rst_n), .opcode(opcode), .instr_valid(instr_valid),
    .has_access_bit(has_access_bit), .file_field(file_field), .access_sel(access_sel),
    .dest_sel(dest_sel), .ext_en(ext_en), .indexed_base_pointer(indexed_base_pointer),
    .bank_select_register(bank_select_register), .eff_addr_q(eff_addr_q), .addr_valid_q(addr_valid_q),
    .dest_to_file_q(dest_to_file_q), .mode_q(mode_q), .ext_opcode_q(ext_opcode_q));
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic wrap_up();
    if (fail_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // One compare for every result, narrow ones zero-extended
  task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Issue one operand instruction at a falling edge, judge it one cycle later
  task automatic op(input logic [7:0] f, input logic a, e, d, input logic [11:0] p, input logic [3:0] b,
                    input logic [11:0] ea, input logic [1:0] m);
    @(negedge clk);
    instr_valid = 1'h1; has_access_bit = 1'h1; file_field = f; access_sel = a;
    ext_en = e; dest_sel = d; indexed_base_pointer = p; bank_select_register = b;
    @(negedge clk);
    chk("eff_addr", ea, eff_addr_q);
    chk("mode", {10'h0, m}, {10'h0, mode_q});
    chk("addr_valid", 12'h1, {11'h0, addr_valid_q});
    chk("dest", {11'h0, d}, {11'h0, dest_to_file_q});
  endtask
  task automatic t_literal();
    op(8'h5f, 1'h0, 1'h0, 1'h0, 12'h123, 4'h2, 12'h05f, 2'h0);
    op(8'h60, 1'h0, 1'h0, 1'h1, 12'h123, 4'h2, 12'hf60, 2'h0);
  endtask
  task automatic t_banked();
    op(8'h10, 1'h1, 1'h0, 1'h0, 12'h100, 4'h3, 12'h310, 2'h1);
    op(8'h10, 1'h1, 1'h1, 1'h1, 12'h100, 4'h5, 12'h510, 2'h1);
  endtask
  // Boundary at 5Fh and a pointer sum that wraps
  task automatic t_indexed();
    op(8'h10, 1'h0, 1'h1, 1'h0, 12'h100, 4'h3, 12'h110, 2'h2);
    op(8'h5f, 1'h0, 1'h1, 1'h1, 12'hffa, 4'h3, 12'h059, 2'h2);
    op(8'h60, 1'h0, 1'h1, 1'h0, 12'h100, 4'h3, 12'hf60, 2'h0);
    op(8'hff, 1'h0, 1'h1, 1'h1, 12'h100, 4'h3, 12'hfff, 2'h0);
  endtask
  task automatic t_zero_ptr();
    op(8'h20, 1'h0, 1'h0, 1'h0, 12'h000, 4'h7, 12'h020, 2'h0);
    op(8'h20, 1'h0, 1'h1, 1'h0, 12'h000, 4'h7, 12'h020, 2'h2);
  endtask
  // Non-operand instruction must leave the address alone
  task automatic t_hold();
    @(negedge clk);
    has_access_bit = 1'h0; dest_sel = 1'h1; file_field = 8'h33;
    @(negedge clk);
    chk("addr_valid", 12'h0, {11'h0, addr_valid_q});
    chk("eff_addr", 12'h020, eff_addr_q);
    chk("mode", 12'h2, {10'h0, mode_q});
    chk("dest", 12'h1, {11'h0, dest_to_file_q});
  endtask
  task automatic t_ext_op();
    @(negedge clk);
    instr_valid = 1'h0; opcode = 16'he803; ext_en = 1'h1;
    @(negedge clk);
    chk("ext_opcode", 12'h1, {11'h0, ext_opcode_q});
    opcode = 16'he880;
    @(negedge clk);
    chk("ext_opcode", 12'h0, {11'h0, ext_opcode_q});
    opcode = 16'hd803;
    @(negedge clk);
    chk("ext_opcode", 12'h0, {11'h0, ext_opcode_q});
    opcode = 16'he803; ext_en = 1'h0;
    @(negedge clk);
    chk("ext_opcode", 12'h0, {11'h0, ext_opcode_q});
  endtask
  // Reset in mid-run clears every result, then decoding resumes
  task automatic t_reset();
    @(negedge clk);
    ext_en = 1'h1;
    @(negedge clk);
    chk("ext_opcode", 12'h1, {11'h0, ext_opcode_q});
    rst_n = 1'h0;
    @(negedge clk);
    chk("eff_addr", 12'h000, eff_addr_q);
    chk("mode", 12'h0, {10'h0, mode_q});
    chk("addr_valid", 12'h0, {11'h0, addr_valid_q});
    chk("dest", 12'h0, {11'h0, dest_to_file_q});
    chk("ext_opcode", 12'h0, {11'h0, ext_opcode_q});
    rst_n = 1'h1;
    op(8'h30, 1'h0, 1'h1, 1'h0, 12'h010, 4'h0, 12'h040, 2'h2);
  endtask
  // Hang guard, far beyond the few dozen cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      wrap_up();
    end
  end
  initial begin
    rst_n = 1'h0; instr_valid = 1'h0; has_access_bit = 1'h0; access_sel = 1'h0; dest_sel = 1'h0;
    ext_en = 1'h0; opcode = 16'h0000; file_field = 8'h00; indexed_base_pointer = 12'h000;
    bank_select_register = 4'h0;
    repeat (5) @(negedge clk);
    rst_n = 1'h1;
    t_literal();
    t_banked();
    t_indexed();
    t_zero_ptr();
    t_hold();
    t_ext_op();
    t_reset();
    wrap_up();
  end
endmodule
